// File: verilog/rpsm_top.sv
/*
 Remappable pin select map: AXI4-Lite register file, four internal virtual
 output routes and the input select routes feeding peripheral inputs.
 Assumes peripherals and port levels run on mclk; remappable pins are
 asynchronous and are synchronised here.
*/
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "rpsm_consts.svh"
module rpsm_top
   import rpsm_pkg::*;
#(
   parameter int ADDR_W    = 12,
   parameter int NUM_FUNCS = 64,
   parameter int NUM_PINS  = 256
) (
   // Clock and reset
   input  wire logic                         mclk,
   input  wire logic                         reset,
   // AXI4-Lite write address
   input  wire logic                         awvalid,
   output logic                              awready,
   input  wire logic [ADDR_W-1:0]            awaddr,
   // AXI4-Lite write data
   input  wire logic                         wvalid,
   output logic                              wready,
   input  wire logic [31:0]                  wdata,
   input  wire logic [3:0]                   wstrb,
   // AXI4-Lite write response
   output logic                              bvalid,
   input  wire logic                         bready,
   output logic [1:0]                        bresp,
   // AXI4-Lite read address
   input  wire logic                         arvalid,
   output logic                              arready,
   input  wire logic [ADDR_W-1:0]            araddr,
   // AXI4-Lite read data
   output logic                              rvalid,
   input  wire logic                         rready,
   output logic [31:0]                       rdata,
   output logic [1:0]                        rresp,
   // Peripheral side, mclk domain
   input  wire logic [NUM_FUNCS-1:0]         periphOut,
   input  wire logic [`RPSM_NUM_VOUT-1:0]    portLevel,
   output logic [2*`RPSM_NUM_IN_REGS-1:0]    periphIn,
   // Virtual outputs 178 to 181, internal only
   output logic [`RPSM_NUM_VOUT-1:0]         virtOut,
   output logic [`RPSM_NUM_VOUT-1:0]         virtMapped,
   // Remappable pins, asynchronous
   input  wire logic [NUM_PINS-1:0]          rpPin
);

   localparam int NIR = `RPSM_NUM_IN_REGS;
   localparam int NVO = `RPSM_NUM_VOUT;

   if (ADDR_W < `RPSM_ADDR_MIN_W || ADDR_W > 32) begin : gBadAddr
      $error("ADDR_W must be 12 to 32");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic                          awHeld;
      logic [`RPSM_WORD_W-1:0]       awWord;
      logic                          wHeld;
      rpsm_reg_t                     wData;
      logic [1:0]                    wStrb;
      logic                          bValid;
      logic [1:0]                    bResp;
      logic                          rValid;
      logic [31:0]                   rData;
      logic [1:0]                    rResp;
      logic                          lock;
      rpsm_reg_t                     outMap18;
      rpsm_reg_t                     outMap19;
      logic [NIR-1:0][`RPSM_REG_W-1:0] inSel;
      logic [NUM_PINS-1:0]           pinMeta;
      logic [NUM_PINS-1:0]           pinSync;
      logic [NVO-1:0]                virtOut;
      logic [NVO-1:0]                virtMapped;
      logic [2*NIR-1:0]              periphIn;
   } rpsm_state_s;

   rpsm_state_s q;
   rpsm_state_s d;

   logic [NVO-1:0]          routeLevel;
   logic [NVO-1:0]          routeMapped;
   logic [2*NIR-1:0]        inLevel;
   rpsm_code_t              voCode [NVO];

   ////////////////////////////////////////////////////////////////////////////////
   // Virtual output routing

   assign voCode[0] = q.outMap18[`RPSM_CODE_LO_LSB +: `RPSM_CODE_W];
   assign voCode[1] = q.outMap18[`RPSM_CODE_HI_LSB +: `RPSM_CODE_W];
   assign voCode[2] = q.outMap19[`RPSM_CODE_LO_LSB +: `RPSM_CODE_W];
   assign voCode[3] = q.outMap19[`RPSM_CODE_HI_LSB +: `RPSM_CODE_W];

   for (genvar v = 0; v < NVO; v++) begin : gOut
      rpsm_out_route #(
         .NUM_FUNCS (NUM_FUNCS)
      ) uOut (
         .code      (voCode[v]),
         .funcs     (periphOut),
         .portLevel (portLevel[v]),
         .level     (routeLevel[v]),
         .mapped    (routeMapped[v])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Peripheral input routing, two fields per select register

   for (genvar s = 0; s < 2 * NIR; s++) begin : gIn
      rpsm_in_route #(
         .NUM_PINS  (NUM_PINS)
      ) uIn (
         .sel       (q.inSel[s / 2][`RPSM_SEL_W * (s % 2) +: `RPSM_SEL_W]),
         .fieldUsed (RPSM_IN_REG_MASK[s / 2][`RPSM_SEL_W * (s % 2)]),
         .pins      (q.pinSync),
         .level     (inLevel[s])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register helpers

   // Byte-lane merge, then drop unimplemented bits
   function automatic rpsm_reg_t mergeWrite(
      input rpsm_reg_t  oldVal,
      input rpsm_reg_t  newVal,
      input logic [1:0] strb,
      input rpsm_reg_t  implMask
   );
      rpsm_reg_t laneMask;
      laneMask = {{8{strb[1]}}, {8{strb[0]}}};
      return ((oldVal & ~laneMask) | (newVal & laneMask)) & implMask;
   endfunction

   // Readback of one word; hit low marks an unmapped address
   function automatic logic [`RPSM_REG_W:0] readWord(
      input logic [`RPSM_WORD_W-1:0] word,
      input rpsm_state_s             st
   );
      logic [`RPSM_REG_W:0] res;
      rpsm_reg_t            stat;
      res  = '0;
      stat = '0;
      stat[NVO-1:0]                           = st.virtOut;
      stat[`RPSM_STAT_MAP_LSB +: NVO]         = st.virtMapped;
      stat[`RPSM_STAT_LOCK_BIT]               = st.lock;
      if (word == `RPSM_WORD_CTRL) begin
         res = {1'b1, `RPSM_CTRL_MASK & (rpsm_reg_t'(st.lock) << `RPSM_LOCK_BIT)};
      end else if (word == `RPSM_WORD_OUT18) begin
         res = {1'b1, st.outMap18 & `RPSM_OUT_MASK};
      end else if (word == `RPSM_WORD_OUT19) begin
         res = {1'b1, st.outMap19 & `RPSM_OUT_MASK};
      end else if (word == `RPSM_WORD_STAT) begin
         res = {1'b1, stat};
      end else begin
         for (int k = 0; k < NIR; k++) begin
            if (word == `RPSM_WORD_IN_BASE + {5'h00, RPSM_IN_REG_IDX[k]}) begin
               res = {1'b1, st.inSel[k] & RPSM_IN_REG_MASK[k]};
            end
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [`RPSM_REG_W:0] rdHit;
      logic [`RPSM_REG_W:0] wrWord;
      logic                 wrHit;
      rdHit  = '0;
      wrWord = '0;
      wrHit  = 1'b0;
      d     = q;

      // Remappable pins cross in through two flops
      d.pinMeta = rpPin;
      d.pinSync = q.pinMeta;

      // Routed levels are registered so data outputs come from flops
      d.virtOut    = routeLevel;
      d.virtMapped = routeMapped;
      d.periphIn   = inLevel;

      // Write address and data are taken in either order
      if (awvalid && awready) begin
         d.awHeld = 1'b1;
         d.awWord = awaddr[`RPSM_WORD_W+1:2];
      end
      if (wvalid && wready) begin
         d.wHeld = 1'b1;
         d.wData = wdata[`RPSM_REG_W-1:0];
         d.wStrb = wstrb[1:0];
      end

      // Write commits once both halves are held
      if (q.awHeld && q.wHeld) begin
         // Function results cannot be indexed directly
         wrWord = readWord(q.awWord, q);
         wrHit  = wrWord[`RPSM_REG_W];
         if (q.awWord == `RPSM_WORD_CTRL) begin
            if (q.wStrb[1]) begin
               d.lock = q.wData[`RPSM_LOCK_BIT];
            end
         end else if (!q.lock) begin
            if (q.awWord == `RPSM_WORD_OUT18) begin
               d.outMap18 = mergeWrite(q.outMap18, q.wData, q.wStrb, `RPSM_OUT_MASK);
            end else if (q.awWord == `RPSM_WORD_OUT19) begin
               d.outMap19 = mergeWrite(q.outMap19, q.wData, q.wStrb, `RPSM_OUT_MASK);
            end else begin
               for (int k = 0; k < NIR; k++) begin
                  if (q.awWord == `RPSM_WORD_IN_BASE + {5'h00, RPSM_IN_REG_IDX[k]}) begin
                     d.inSel[k] = mergeWrite(q.inSel[k], q.wData, q.wStrb, RPSM_IN_REG_MASK[k]);
                  end
               end
            end
         end
         d.awHeld = 1'b0;
         d.wHeld  = 1'b0;
         d.bValid = 1'b1;
         d.bResp  = wrHit ? `RPSM_RESP_OKAY : `RPSM_RESP_SLVERR;
      end
      if (q.bValid && bready) begin
         d.bValid = 1'b0;
      end

      // Reads answer one cycle after the address is taken
      if (q.rValid && rready) begin
         d.rValid = 1'b0;
      end
      if (arvalid && arready) begin
         rdHit    = readWord(araddr[`RPSM_WORD_W+1:2], q);
         d.rValid = 1'b1;
         d.rData  = {`RPSM_DATA_PAD, rdHit[`RPSM_REG_W-1:0]};
         d.rResp  = rdHit[`RPSM_REG_W] ? `RPSM_RESP_OKAY : `RPSM_RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Ready held low while a response waits, so one of each at a time
   assign awready = !q.awHeld && !q.bValid;
   assign wready  = !q.wHeld && !q.bValid;
   assign arready = !q.rValid;
   assign bvalid  = q.bValid;
   assign bresp   = q.bResp;
   assign rvalid  = q.rValid;
   assign rdata   = q.rData;
   assign rresp   = q.rResp;

   // No pad: these levels only reach internal logic
   assign virtOut    = q.virtOut;
   assign virtMapped = q.virtMapped;
   assign periphIn   = q.periphIn;

endmodule

// File: verilog/rpsm_consts.svh
/*
 Constants of the remappable pin select map: word offsets, field layout,
 implemented-bit masks and bus answer codes.
 Assumes it is included by bare name; the guard makes repeated inclusion harmless.
*/
`ifndef RPSM_CONSTS_SVH
`define RPSM_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Word offsets (byte address = 4 * word)
`define RPSM_WORD_CTRL      10'h000
`define RPSM_WORD_OUT18     10'h001
`define RPSM_WORD_OUT19     10'h002
`define RPSM_WORD_STAT      10'h003
`define RPSM_WORD_IN_BASE   10'h040
`define RPSM_WORD_W         10
`define RPSM_ADDR_MIN_W     12

////////////////////////////////////////////////////////////////////////////////
// Field layout
`define RPSM_LOCK_BIT       11
`define RPSM_CODE_LO_LSB    0
`define RPSM_CODE_HI_LSB    8
`define RPSM_CODE_W         6
`define RPSM_SEL_W          8
`define RPSM_REG_W          16
`define RPSM_NUM_VOUT       4
`define RPSM_NUM_IN_REGS    22
`define RPSM_STAT_MAP_LSB   4
`define RPSM_STAT_LOCK_BIT  8

////////////////////////////////////////////////////////////////////////////////
// Implemented-bit masks and reset value
`define RPSM_OUT_MASK       16'h3f3f
`define RPSM_CTRL_MASK      16'h0800
`define RPSM_IN_FULL        16'hffff
`define RPSM_IN_HI          16'hff00
`define RPSM_IN_LO          16'h00ff
`define RPSM_REG_RESET      16'h0000

////////////////////////////////////////////////////////////////////////////////
// Bus answers
`define RPSM_RESP_OKAY      2'h0
`define RPSM_RESP_SLVERR    2'h2
`define RPSM_DATA_PAD       16'h0000

`endif

// File: verilog/rpsm_pkg.sv
/*
 Types and register tables of the remappable pin select map.
 Assumes rpsm_consts.svh is on the include path.
*/
package rpsm_pkg;
`include "rpsm_consts.svh"

   typedef logic [`RPSM_REG_W-1:0]  rpsm_reg_t;
   typedef logic [`RPSM_CODE_W-1:0] rpsm_code_t;
   typedef logic [`RPSM_SEL_W-1:0]  rpsm_sel_t;
   typedef logic [4:0]              rpsm_idx_t;

   // Printed index of each input select register, in slot order
   localparam rpsm_idx_t RPSM_IN_REG_IDX [`RPSM_NUM_IN_REGS] = '{
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
      5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12,
      5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h1b};

   // Implemented fields of each input select register
   localparam rpsm_reg_t RPSM_IN_REG_MASK [`RPSM_NUM_IN_REGS] = '{
      `RPSM_IN_HI,   `RPSM_IN_FULL, `RPSM_IN_HI,   `RPSM_IN_FULL,
      `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL,
      `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL,
      `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL,
      `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL, `RPSM_IN_FULL,
      `RPSM_IN_LO,   `RPSM_IN_FULL};
endpackage

// File: verilog/rpsm_out_route.sv
/*
 One remappable output: picks a peripheral output by its function code.
 Assumes the code and function levels come from the mclk domain.
*/
`timescale 1ns/1ps
`include "rpsm_consts.svh"
module rpsm_out_route
   import rpsm_pkg::*;
#(
   parameter int NUM_FUNCS = 64
) (
   // Selection
   input  wire rpsm_code_t             code,
   // Sources
   input  wire logic [NUM_FUNCS-1:0]   funcs,
   input  wire logic                   portLevel,
   // Result
   output logic                        level,
   output logic                        mapped
);

   if (NUM_FUNCS < 2 || NUM_FUNCS > (1 << `RPSM_CODE_W)) begin : gBadFuncs
      $error("NUM_FUNCS out of range for a 6-bit code");
   end

   always_comb begin
      level  = portLevel;
      mapped = 1'b0;
      if (code != '0 && int'(code) < NUM_FUNCS) begin
         level  = funcs[code];
         mapped = 1'b1;
      end
   end

endmodule

// File: verilog/rpsm_in_route.sv
/*
 One peripheral input: picks a remappable pin by an 8-bit selector.
 Assumes the pins are already synchronised to mclk.
*/
`timescale 1ns/1ps
`include "rpsm_consts.svh"
module rpsm_in_route
   import rpsm_pkg::*;
#(
   parameter int NUM_PINS = 256
) (
   // Selection
   input  wire rpsm_sel_t             sel,
   input  wire logic                  fieldUsed,
   // Sources
   input  wire logic [NUM_PINS-1:0]   pins,
   // Result
   output logic                       level
);

   if (NUM_PINS < 1 || NUM_PINS > (1 << `RPSM_SEL_W)) begin : gBadPins
      $error("NUM_PINS out of range for an 8-bit selector");
   end

   // Selectors beyond the pin count read low rather than wrap
   always_comb begin
      level = 1'b0;
      if (fieldUsed && int'(sel) < NUM_PINS) begin
         level = pins[sel];
      end
   end

endmodule

// File: verification/rpsm_top_asserts.sv
/*
 Port-level checks of rpsm_top, attached by bind.
 Assumes one mclk domain with a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "rpsm_consts.svh"
module rpsm_top_asserts
   import rpsm_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic                               mclk,
   input wire logic                               reset,
   // Register bus
   input wire logic                               awvalid,
   input wire logic                               awready,
   input wire logic                               wvalid,
   input wire logic                               wready,
   input wire logic                               bvalid,
   input wire logic                               bready,
   input wire logic [1:0]                         bresp,
   input wire logic                               arvalid,
   input wire logic                               arready,
   input wire logic [ADDR_W-1:0]                  araddr,
   input wire logic                               rvalid,
   input wire logic                               rready,
   input wire logic [31:0]                        rdata,
   input wire logic [1:0]                         rresp,
   // Routed levels
   input wire logic [`RPSM_NUM_VOUT-1:0]          portLevel,
   input wire logic [`RPSM_NUM_VOUT-1:0]          virtOut,
   input wire logic [`RPSM_NUM_VOUT-1:0]          virtMapped,
   input wire logic [2*`RPSM_NUM_IN_REGS-1:0]     periphIn
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (reset);

   sequence wrTaken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence rdMap;
      arvalid && arready && (araddr[ADDR_W-1:2] == 1 || araddr[ADDR_W-1:2] == 2);
   endsequence
   sequence rdFar;
      arvalid && arready && araddr[ADDR_W-1:9] != 0;
   endsequence

   //////////////////////////////////////////////////////////////////////
   chk_write_answer: assert property (wrTaken |=> !bvalid ##1 bvalid)
      else $error("write answer not two edges after take");
   chk_bresp_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   chk_write_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   chk_rdata_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   chk_map_unused: assert property (rdMap |=> (rdata & 32'hffff_c0c0) == 0)
      else $error("unused map bits read nonzero");
   chk_far_read: assert property (rdFar |=> rresp == `RPSM_RESP_SLVERR && rdata == 0)
      else $error("unmapped read not refused");
   chk_reset_clear: assert property (disable iff (1'b0) reset |=> !bvalid && !rvalid && virtMapped == 0 && periphIn == 0)
      else $error("reset left state behind");
   chk_port_fallback: assert property (!$past(reset) |-> ((virtOut ^ $past(portLevel)) & ~virtMapped) == 0)
      else $error("unassigned output not at port level");
endmodule

bind rpsm_top rpsm_top_asserts #(.ADDR_W(ADDR_W)) chk (.mclk, .reset, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .portLevel, .virtOut,
   .virtMapped, .periphIn);

// File: verification/rpsm_periph_model.sv
/*
 Stand-in for the peripherals and remappable pins around rpsm_top.
 Assumes the bench asks for levels just after a rising edge.
*/
`timescale 1ns/1ps
module rpsm_periph_model #(
   parameter int NUM_FUNCS = 64,
   parameter int NUM_PINS  = 256
) (
   // Clock
   input  wire logic                 mclk,
   // Levels asked for by the bench
   input  wire logic [NUM_FUNCS-1:0] funcReq,
   input  wire logic [3:0]           portReq,
   input  wire logic [NUM_PINS-1:0]  pinReq,
   // Toward the block
   output logic      [NUM_FUNCS-1:0] periphOut = '0,
   output logic      [3:0]           portLevel = '0,
   output logic      [NUM_PINS-1:0]  rpPin     = '0
);
   // Pins move off the clock phase, as real pads would
   always @(posedge mclk) begin
      periphOut <= funcReq;
      portLevel <= portReq;
      rpPin     <= #1.3 pinReq;
   end
endmodule

// File: verification/tb_top.sv
/*
 Self-checking bench for rpsm_top: register traffic, output routing, input selects.
 Assumes rpsm_periph_model stands in for peripherals and pins.
*/
`timescale 1ns/1ps
`include "rpsm_consts.svh"
module tb_top
   import rpsm_pkg::*;
;
   logic         mclk = 1'b0, reset = 1'b1;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
   logic [31:0]  wdata = 32'h0, rdata;
   logic [3:0]   wstrb = 4'h0, portLevel, virtOut, virtMapped, portReq = 4'h0;
   logic [1:0]   bresp, rresp, resp;
   logic [63:0]  periphOut, funcReq = 64'h0;
   logic [255:0] rpPin, pinReq = 256'h0;
   logic [43:0]  periphIn;
   logic [11:0]  zeroAddr [6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h104, 12'h16c};
   rpsm_reg_t    got;
   int           n_errors = 0, checks = 0, i;

   always #2.5 mclk = ~mclk;

   rpsm_top uut (.mclk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
      .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .periphOut, .portLevel, .periphIn,
      .virtOut, .virtMapped, .rpPin);
   rpsm_periph_model model (.mclk, .funcReq, .portReq, .pinReq, .periphOut, .portLevel, .rpPin);

   ////////////////////////////////////////////////////////////////////////
   task automatic note(input logic bad);
      checks++;
      if (bad) n_errors++;
   endtask
   task automatic cmpData(input rpsm_reg_t g, input rpsm_reg_t e);
      if (g !== e) $display("FAIL %0t data %h expected %h", $time, g, e);
      note(g !== e);
   endtask
   task automatic cmpLvl(input logic [3:0] g, input logic [3:0] e);
      if (g !== e) $display("FAIL %0t levels %b expected %b", $time, g, e);
      note(g !== e);
   endtask
   task automatic cmpResp(input logic [1:0] g, input logic [1:0] e);
      if (g !== e) $display("FAIL %0t response %h expected %h", $time, g, e);
      note(g !== e);
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // A bus that never answers must not hang the run
   task automatic limit(input int k);
      if (k >= 40) begin
         n_errors++;
         $display("FAIL %0t bus wait ran out", $time);
         stop_test;
      end
   endtask
   task automatic tick(inout int k);
      @(posedge mclk);
      k++;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input rpsm_reg_t d);
      logic ad, dd;
      int   k;
      ad = 1'b0;
      dd = 1'b0;
      k = 0;
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= {16'h0000, d};
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         tick(k);
         ad = ad | awready;
         dd = dd | wready;
         awvalid <= !ad;
         wvalid  <= !dd;
      end while (k < 40 && !(ad && dd));
      do tick(k); while (k < 40 && bvalid !== 1'b1);
      limit(k);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      int k;
      k = 0;
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do tick(k); while (k < 40 && arready !== 1'b1);
      arvalid <= 1'b0;
      do tick(k); while (k < 40 && rvalid !== 1'b1);
      limit(k);
      got = rdata[15:0];
      resp = rresp;
      rready <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      foreach (zeroAddr[j]) begin
         rd(zeroAddr[j]);
         cmpData(got, 16'h0000);
      end
      cmpLvl(virtMapped, 4'h0);
      wr(12'h004, 16'hffff);
      rd(12'h004);
      cmpData(got, 16'h3f3f);
      wr(12'h004, 16'h0509);
      wr(12'h008, 16'h2a11);
      // Opposite patterns so a stuck route shows
      for (i = 0; i < 2; i++) begin
         funcReq <= i ? ~64'h0000_0400_0002_0020 : 64'h0000_0400_0002_0020;
         repeat (3) @(posedge mclk);
         cmpLvl(virtMapped, 4'hf);
         cmpLvl(virtOut, {funcReq[42], funcReq[17], funcReq[5], funcReq[9]});
      end
      wr(12'h008, 16'h0000);
      for (i = 0; i < 2; i++) begin
         portReq <= i ? 4'h5 : 4'ha;
         repeat (3) @(posedge mclk);
         cmpLvl(virtMapped, 4'h3);
         cmpLvl(virtOut, {portReq[3:2], funcReq[5], funcReq[9]});
      end
      wr(12'h104, 16'h0307);
      wr(12'h100, 16'hffff);
      rd(12'h100);
      cmpData(got, 16'hff00);
      for (i = 0; i < 2; i++) begin
         pinReq <= i ? ~256'h80 : 256'h80;
         repeat (5) @(posedge mclk);
         cmpLvl(periphIn[3:0], {pinReq[3], pinReq[7], pinReq[255], 1'b0});
      end
      wr(12'h000, 16'hffff);
      rd(12'h000);
      cmpData(got, 16'h0800);
      // Status word: lock, mapped flags and routed levels
      rd(12'h00c);
      cmpData(got, {7'h00, 1'b1, 4'h3, portReq[3:2], funcReq[5], funcReq[9]});
      wr(12'h004, 16'h0102);
      wr(12'h104, 16'h0000);
      cmpResp(resp, 2'h0);
      rd(12'h004);
      cmpData(got, 16'h0509);
      rd(12'h104);
      cmpData(got, 16'h0307);
      wr(12'h000, 16'h0000);
      wr(12'h004, 16'h0102);
      rd(12'h004);
      cmpData(got, 16'h0102);
      // An unmapped word is wholly unimplemented
      wr(12'h200, 16'h1234);
      cmpResp(resp, 2'h2);
      rd(12'h200);
      cmpResp(resp, 2'h2);
      cmpData(got, 16'h0000);
      stop_test;
   end
endmodule
